// [dagc_pkg.sv]
/*
 * Constants shared by the digital gain control block: register map, field
 * positions, values after reset and the widths of the level arithmetic.
 * Assumes an AXI4-Lite master with 32-bit data and byte addresses.
 */
package dagc_pkg;
    // Register byte offsets.
    localparam logic [7:0] DAGC_CTRL_OFFS = 8'h00;
    localparam logic [7:0] DAGC_RSSI_CORR_OFFS = 8'h04;
    localparam logic [7:0] DAGC_PMF_OFFS = 8'h08;
    localparam logic [7:0] DAGC_THR_OFFSET_OFFS = 8'h0c;
    localparam logic [7:0] DAGC_THR_LOW_OFFS = 8'h10;
    localparam logic [7:0] DAGC_THR_UP_OFFS = 8'h14;
    localparam logic [7:0] DAGC_HYS_OFFS = 8'h18;
    localparam logic [7:0] DAGC_DGC_OFFS = 8'h1c;
    localparam logic [7:0] DAGC_STATUS_OFFS = 8'h20;
    localparam logic [7:0] DAGC_LEVELS_OFFS = 8'h24;
    // Field positions.
    localparam int DAGC_DDC_BIT = 4;
    localparam int DAGC_SLOPE_POS = 16;
    localparam int DAGC_DECAY_POS = 8;
    localparam int DAGC_LEVEL_POS = 16;
    localparam int DAGC_DELOG_POS = 16;
    // Levels are in units of 0.1 dB.
    localparam int DAGC_LVL_W = 12;
    localparam int DAGC_SAMPLE_W = 10;
    localparam int DAGC_SLOPE_FRAC = 6;
    localparam int DAGC_ACC_FRAC = 8;
    // Values after reset, the single conversion attenuation limit and the AXI response codes.
    localparam logic [3:0] DAGC_ATT_RST = 4'h0;
    localparam logic [3:0] DAGC_SDC_ATT_MAX = 4'h7;
    localparam logic [10:0] DAGC_OFFS_RST = 11'h000;
    localparam logic [7:0] DAGC_SLOPE_RST = 8'h40;
    localparam logic [3:0] DAGC_ATTACK_RST = 4'h4;
    localparam logic [3:0] DAGC_DECAY_RST = 4'h4;
    localparam logic [11:0] DAGC_THR_OFFSET_RST = 12'h27f;
    localparam logic [11:0] DAGC_THR_LOW_RST = 12'h080;
    localparam logic [11:0] DAGC_THR_UP_RST = 12'h100;
    localparam logic [11:0] DAGC_HYS_RST = 12'h0d5;
    localparam logic [11:0] DAGC_DGC_RST = 12'h09b;
    localparam logic [1:0] DAGC_RESP_OKAY = 2'h0;
    localparam logic [1:0] DAGC_RESP_DECERR = 2'h3;
endpackage : dagc_pkg

// [dagc_rf_model.sv]
/*
 * Model of the RSSI converter feeding the gain control block.
 * Assumes the bench sets the analog level; one conversion every eight clocks.
 */
`timescale 1ns/1ps
module dagc_rf_model
    import dagc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [DAGC_SAMPLE_W-1:0] level,
    output logic [DAGC_SAMPLE_W-1:0] rssi_sample,
    output logic rssi_valid
);
    logic [2:0] count;
    // The code is only valid in the pulse cycle, so the line toggles in between to expose stale reads.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 3'h0;
            rssi_valid <= 1'h0;
            rssi_sample <= '0;
        end else begin
            count <= count + 3'h1;
            rssi_valid <= (count == 3'h7);
            rssi_sample <= (count == 3'h7) ? level : ~rssi_sample;
        end
    end
endmodule // dagc_rf_model

// [dagc_top.sv]
/*
 * Digital automatic gain control: RSSI correction, peak memory integrator,
 * two Schmitt triggers choosing one of three second-IF gain steps, digital
 * gain correction and the delog lookup, with an AXI4-Lite register slave.
 * Assumes one clock, RSSI samples marked by a one-cycle rssi_valid pulse.
 */
// Chosen here: the register offsets and the AXI4-Lite slave port.
// What this block does
// [R1] Four-bit first IF buffer attenuation setting
// [R2] Second IF gain takes exactly three values
// [R3] Gain point moves with conversion mode
// [R4] RSSI corrected by offset then slope
// [R5] Peak integrator with attack and decay coefficients
// [R6] Software sets decay much slower than attack
// [R7] Two Schmitt triggers at low, upper thresholds
// [R8] One shared hysteresis sets release thresholds
// [R9] Triggers drive analog step and digital correction
// [R10] Integrator error indexes the delog table
// [R11] Thresholds in dB, offset default 63.9 dB
// [R12] Switch level is offset plus threshold
// [R13] Below low minus hysteresis, maximum gain
// [R14] State updates once per RSSI sample
`timescale 1ns/1ps
module dagc_top
    import dagc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [DAGC_SAMPLE_W-1:0] rssi_sample,
    input wire logic rssi_valid,
    output logic [3:0] if_attenuation_setting,
    output logic double_conversion_mode,
    output logic gain_after_polyphase,
    output logic gain_before_mixer,
    output logic [1:0] gain_step,
    output logic [DAGC_LVL_W-1:0] digital_gain_correction,
    output logic [DAGC_LVL_W-1:0] corrected_rssi,
    output logic [DAGC_LVL_W-1:0] filtered_level,
    output logic [7:0] delog_index,
    output logic [9:0] delog_value
);
    logic [3:0] att_reg;
    logic [10:0] rssi_offset_correction;
    logic [7:0] rssi_slope_correction;
    logic [3:0] attack_coefficient;
    logic [3:0] decay_coefficient;
    logic [11:0] threshold_offset;
    logic [11:0] low_gain_threshold;
    logic [11:0] upper_gain_threshold;
    logic [11:0] threshold_hysteresis;
    logic [11:0] dgc_step;
    logic [DAGC_LVL_W+DAGC_ACC_FRAC-1:0] pmf_acc;
    logic low_on;
    logic up_on;
    logic aw_full;
    logic w_full;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;

    // Byte-lane merge of a write into a register's present contents.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Linear amplitude (1.0 = 256) in steps of 1.6 dB of the error signal.
    function automatic logic [9:0] delog_lut(input logic [3:0] k);
        case (k)
            4'h8: return 10'h03b;
            4'h9: return 10'h047;
            4'ha: return 10'h055;
            4'hb: return 10'h066;
            4'hc: return 10'h07a;
            4'hd: return 10'h093;
            4'he: return 10'h0b1;
            4'hf: return 10'h0d5;
            4'h0: return 10'h100;
            4'h1: return 10'h134;
            4'h2: return 10'h172;
            4'h3: return 10'h1bd;
            4'h4: return 10'h217;
            4'h5: return 10'h283;
            4'h6: return 10'h305;
            default: return 10'h3a1;
        endcase
    endfunction

    // AXI write channels: address and data are taken independently.
    assign do_write = aw_full && w_full && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            s_axi_awready <= 1'b1;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            s_axi_awready <= 1'b0;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_full <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full <= 1'b0;
            s_axi_wready <= 1'b1;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            s_axi_wready <= 1'b0;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_full <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= DAGC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr[7:2] <= DAGC_DGC_OFFS[7:2]) ? DAGC_RESP_OKAY : DAGC_RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register writes; the low two address bits are ignored.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            att_reg <= DAGC_ATT_RST;
            double_conversion_mode <= 1'b1;
            rssi_offset_correction <= DAGC_OFFS_RST;
            rssi_slope_correction <= DAGC_SLOPE_RST;
            attack_coefficient <= DAGC_ATTACK_RST;
            decay_coefficient <= DAGC_DECAY_RST;
            // [R11] threshold offset default
            threshold_offset <= DAGC_THR_OFFSET_RST;
            low_gain_threshold <= DAGC_THR_LOW_RST;
            upper_gain_threshold <= DAGC_THR_UP_RST;
            threshold_hysteresis <= DAGC_HYS_RST;
            dgc_step <= DAGC_DGC_RST;
        end else if (do_write) begin
            case ({aw_addr[7:2], 2'b00})
                DAGC_CTRL_OFFS: begin
                    att_reg <= 4'(merge({27'h0, double_conversion_mode, att_reg}, w_data, w_strb));
                    double_conversion_mode <= w_strb[0] ? w_data[DAGC_DDC_BIT] : double_conversion_mode;
                end
                DAGC_RSSI_CORR_OFFS: begin
                    rssi_offset_correction <= 11'(merge({8'h0, rssi_slope_correction, 5'h0, rssi_offset_correction},
                        w_data, w_strb));
                    rssi_slope_correction <= w_strb[2] ? w_data[DAGC_SLOPE_POS +: 8] : rssi_slope_correction;
                end
                DAGC_PMF_OFFS: begin
                    attack_coefficient <= w_strb[0] ? w_data[3:0] : attack_coefficient;
                    decay_coefficient <= w_strb[1] ? w_data[DAGC_DECAY_POS +: 4] : decay_coefficient;
                end
                DAGC_THR_OFFSET_OFFS: threshold_offset <= 12'(merge({20'h0, threshold_offset}, w_data, w_strb));
                DAGC_THR_LOW_OFFS: low_gain_threshold <= 12'(merge({20'h0, low_gain_threshold}, w_data, w_strb));
                DAGC_THR_UP_OFFS: upper_gain_threshold <= 12'(merge({20'h0, upper_gain_threshold}, w_data, w_strb));
                DAGC_HYS_OFFS: threshold_hysteresis <= 12'(merge({20'h0, threshold_hysteresis}, w_data, w_strb));
                DAGC_DGC_OFFS: dgc_step <= 12'(merge({20'h0, dgc_step}, w_data, w_strb));
                default: begin
                end
            endcase
        end
    end

    // AXI read: one cycle from address acceptance to rvalid.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= DAGC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= DAGC_RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                DAGC_CTRL_OFFS: s_axi_rdata <= {27'h0, double_conversion_mode, att_reg};
                DAGC_RSSI_CORR_OFFS: s_axi_rdata <= {8'h0, rssi_slope_correction, 5'h0, rssi_offset_correction};
                DAGC_PMF_OFFS: s_axi_rdata <= {20'h0, decay_coefficient, 4'h0, attack_coefficient};
                DAGC_THR_OFFSET_OFFS: s_axi_rdata <= {20'h0, threshold_offset};
                DAGC_THR_LOW_OFFS: s_axi_rdata <= {20'h0, low_gain_threshold};
                DAGC_THR_UP_OFFS: s_axi_rdata <= {20'h0, upper_gain_threshold};
                DAGC_HYS_OFFS: s_axi_rdata <= {20'h0, threshold_hysteresis};
                DAGC_DGC_OFFS: s_axi_rdata <= {20'h0, dgc_step};
                DAGC_STATUS_OFFS: s_axi_rdata <= {4'h0, filtered_level, 14'h0, gain_step};
                DAGC_LEVELS_OFFS: s_axi_rdata <= {6'h0, delog_value, 4'h0, corrected_rssi};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= DAGC_RESP_DECERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // [R1] [R3] attenuation and gain point
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            if_attenuation_setting <= DAGC_ATT_RST;
            gain_after_polyphase <= 1'b0;
            gain_before_mixer <= 1'b1;
        end else begin
            // Single conversion has a shorter attenuation ladder, so the setting is clamped.
            if_attenuation_setting <= (!double_conversion_mode && att_reg > DAGC_SDC_ATT_MAX) ?
                DAGC_SDC_ATT_MAX : att_reg;
            gain_after_polyphase <= !double_conversion_mode;
            gain_before_mixer <= double_conversion_mode;
        end
    end

    // Sample-path arithmetic, all in units of 0.1 dB.
    logic signed [11:0] offs_sum;
    logic signed [20:0] slope_prod;
    logic signed [14:0] scaled;
    logic [DAGC_LVL_W-1:0] next_corrected;
    logic [12:0] comp_sum;
    logic [DAGC_LVL_W-1:0] comp_level;
    logic signed [13:0] pmf_err;
    logic [4:0] shift;
    logic signed [22:0] pmf_delta;
    logic signed [22:0] acc_sum;
    logic [DAGC_LVL_W+DAGC_ACC_FRAC-1:0] next_acc;
    logic [DAGC_LVL_W-1:0] next_level;
    logic [12:0] low_level;
    logic [12:0] up_level;
    logic [13:0] low_release;
    logic [13:0] up_release;
    logic next_low_on;
    logic next_up_on;
    logic [7:0] next_index;

    always_comb begin
        // [R4] offset then slope
        offs_sum = $signed({2'b00, rssi_sample}) + $signed({rssi_offset_correction[10], rssi_offset_correction});
        slope_prod = 21'(offs_sum * $signed({1'b0, rssi_slope_correction}));
        scaled = 15'(slope_prod >>> DAGC_SLOPE_FRAC);
        next_corrected = (scaled < 0) ? '0 : (scaled > 15'sd4095) ? 12'hfff : scaled[11:0];
        // [R9] digital correction restores the level lost to the analog step
        comp_sum = {1'b0, next_corrected} + {1'b0, digital_gain_correction};
        comp_level = comp_sum[12] ? 12'hfff : comp_sum[11:0];
        // [R5] attack when rising, decay (relative to attack) when falling
        pmf_err = $signed({2'b00, comp_level}) - $signed({2'b00, pmf_acc[19:8]});
        shift = (pmf_err > 0) ? {1'b0, attack_coefficient} : 5'({1'b0, attack_coefficient} + {1'b0, decay_coefficient});
        if (shift > 5'd22) begin
            shift = 5'd22;
        end
        pmf_delta = ($signed({{9{pmf_err[13]}}, pmf_err}) <<< DAGC_ACC_FRAC) >>> shift;
        acc_sum = $signed({3'b000, pmf_acc}) + pmf_delta;
        next_acc = (acc_sum < 0) ? '0 : acc_sum[19:0];
        next_level = next_acc[19:8];
        // [R12] switching level is offset plus threshold
        low_level = {1'b0, threshold_offset} + {1'b0, low_gain_threshold};
        up_level = {1'b0, threshold_offset} + {1'b0, upper_gain_threshold};
        // [R8] one hysteresis below each attack level
        low_release = {1'b0, low_level} - {2'b00, threshold_hysteresis};
        up_release = {1'b0, up_level} - {2'b00, threshold_hysteresis};
        // [R7] two Schmitt triggers
        next_low_on = low_on;
        if ({1'b0, next_level} >= low_level) begin
            next_low_on = 1'b1;
        // [R13] back to maximum gain below release level
        end else if (!low_release[13] && {2'b00, next_level} < low_release) begin
            next_low_on = 1'b0;
        end
        next_up_on = up_on;
        if ({1'b0, next_level} >= up_level) begin
            next_up_on = 1'b1;
        end else if (!up_release[13] && {2'b00, next_level} < up_release) begin
            next_up_on = 1'b0;
        end
        // [R10] error clamped to the table's index range
        next_index = (pmf_err > 14'sd127) ? 8'h7f : (pmf_err < -14'sd128) ? 8'h80 : pmf_err[7:0];
    end

    // [R14] integrator and triggers advance per sample
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pmf_acc <= '0;
            low_on <= 1'b0;
            up_on <= 1'b0;
            gain_step <= 2'h0;
            digital_gain_correction <= '0;
            corrected_rssi <= '0;
            filtered_level <= '0;
            delog_index <= 8'h00;
            delog_value <= 10'h100;
        end else if (rssi_valid) begin
            pmf_acc <= next_acc;
            low_on <= next_low_on;
            up_on <= next_up_on;
            // [R2] three steps: 0, 1 or 2 reductions
            gain_step <= {1'b0, next_low_on} + {1'b0, next_up_on};
            digital_gain_correction <= (next_low_on && next_up_on) ? 12'(dgc_step << 1) :
                (next_low_on || next_up_on) ? dgc_step : '0;
            corrected_rssi <= next_corrected;
            filtered_level <= next_level;
            delog_index <= next_index;
            delog_value <= delog_lut(next_index[7:4]);
        end
    end

    sequence s_sample;
        rssi_valid;
    endsequence

    sequence s_no_sample;
        !rssi_valid;
    endsequence

    property p_sdc_clamp;
        @(posedge aclk) disable iff (!aresetn)
        !double_conversion_mode ##1 !double_conversion_mode |-> if_attenuation_setting <= DAGC_SDC_ATT_MAX;
    endproperty
    a_sdc_clamp: assert property (p_sdc_clamp) else $error("attenuation exceeds single conversion range"); // [R1]

    property p_three_steps;
        @(posedge aclk) disable iff (!aresetn) gain_step != 2'h3 && (up_on -> low_on || gain_step != 2'h0);
    endproperty
    a_three_steps: assert property (p_three_steps) else $error("illegal gain step"); // [R2]

    property p_gain_point;
        @(posedge aclk) disable iff (!aresetn) ##1 (gain_after_polyphase == $past(!double_conversion_mode))
            && (gain_before_mixer != gain_after_polyphase);
    endproperty
    a_gain_point: assert property (p_gain_point) else $error("gain point does not follow mode"); // [R3]

    property p_correction;
        @(posedge aclk) disable iff (!aresetn) s_sample |=> corrected_rssi == $past(next_corrected)
            && ($past(rssi_slope_correction) != DAGC_SLOPE_RST || $past(rssi_offset_correction) != 11'h0
            || corrected_rssi == 12'($past(rssi_sample)));
    endproperty
    a_correction: assert property (p_correction) else $error("RSSI correction mismatch"); // [R4]

    property p_attack;
        @(posedge aclk) disable iff (!aresetn) s_sample and (pmf_err > 0) |=> filtered_level >= $past(filtered_level);
    endproperty
    a_attack: assert property (p_attack) else $error("integrator fell on rising input"); // [R5]

    property p_low_switch;
        @(posedge aclk) disable iff (!aresetn) s_sample and ({1'b0, next_level} >= low_level) |=> gain_step >= 2'h1;
    endproperty
    a_low_switch: assert property (p_low_switch) else $error("low trigger did not switch"); // [R7]

    property p_hyst_hold;
        @(posedge aclk) disable iff (!aresetn)
        s_sample and low_on and ({2'b00, next_level} >= low_release) |=> gain_step != 2'h0;
    endproperty
    a_hyst_hold: assert property (p_hyst_hold) else $error("released inside hysteresis"); // [R8]

    property p_dgc_match;
        @(posedge aclk) disable iff (!aresetn)
        s_sample |=> digital_gain_correction == 12'($past(dgc_step) * gain_step);
    endproperty
    a_dgc_match: assert property (p_dgc_match) else $error("digital correction not matched"); // [R9]

    property p_delog;
        @(posedge aclk) disable iff (!aresetn) s_sample |=> delog_index == $past(next_index)
            && delog_value == delog_lut(delog_index[7:4]);
    endproperty
    a_delog: assert property (p_delog) else $error("delog index not from error"); // [R10]

    property p_defaults;
        @(posedge aclk) disable iff (!aresetn) $rose(aresetn) |-> threshold_offset == DAGC_THR_OFFSET_RST
            && low_gain_threshold == DAGC_THR_LOW_RST && upper_gain_threshold == DAGC_THR_UP_RST;
    endproperty
    a_defaults: assert property (p_defaults) else $error("threshold defaults wrong"); // [R11] [R12]

    property p_max_gain;
        @(posedge aclk) disable iff (!aresetn) s_sample and !low_release[13] and !up_release[13]
            and ({2'b00, next_level} < low_release) and (low_release <= up_release) |=> gain_step == 2'h0;
    endproperty
    a_max_gain: assert property (p_max_gain) else $error("gain not back to maximum"); // [R13]

    property p_hold;
        @(posedge aclk) disable iff (!aresetn) s_no_sample |=> $stable(gain_step) && $stable(filtered_level);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved without a sample"); // [R14]

    property p_read_latency;
        @(posedge aclk) disable iff (!aresetn) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("read answer late");
endmodule // dagc_top

// [test_digital_agc_peak_filter.sv]
/*
 * Self-checking bench for dagc_top: register map, attenuation, RSSI correction and gain switching.
 * Assumes dagc_rf_model supplies the RSSI samples.
 */
`timescale 1ns/1ps
module test_digital_agc_peak_filter
    import dagc_pkg::*;
;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rssi_valid;
    logic double_conversion_mode, gain_after_polyphase, gain_before_mixer;
    logic [7:0] s_axi_awaddr, s_axi_araddr, delog_index;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb, if_attenuation_setting;
    logic [1:0] s_axi_bresp, s_axi_rresp, gain_step, resp;
    logic [DAGC_LVL_W-1:0] digital_gain_correction, corrected_rssi, filtered_level;
    logic [9:0] delog_value;
    logic [DAGC_SAMPLE_W-1:0] rssi_sample, level;
    int num_errors = 0;
    int n_tests = 0;
    dagc_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .rssi_sample, .rssi_valid, .if_attenuation_setting, .double_conversion_mode,
        .gain_after_polyphase, .gain_before_mixer, .gain_step, .digital_gain_correction,
        .corrected_rssi, .filtered_level, .delog_index, .delog_value);
    dagc_rf_model i_rf (.aclk, .aresetn, .level, .rssi_sample, .rssi_valid);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw, pb;
        pa = 1'h1;
        pw = 1'h1;
        pb = 1'h1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (pa || pw || pb) begin
            @(posedge aclk);
            if (pa && s_axi_awready) begin
                pa = 1'h0;
                s_axi_awvalid <= 1'h0;
            end
            if (pw && s_axi_wready) begin
                pw = 1'h0;
                s_axi_wvalid <= 1'h0;
            end
            if (pb && s_axi_bvalid) begin
                pb = 1'h0;
                resp = s_axi_bresp;
                s_axi_bready <= 1'h0;
            end
        end
    endtask
    task automatic axi_rd(input logic [7:0] a);
        logic pa, pd;
        pa = 1'h1;
        pd = 1'h1;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (pa || pd) begin
            @(posedge aclk);
            if (pa && s_axi_arready) begin
                pa = 1'h0;
                s_axi_arvalid <= 1'h0;
            end
            if (pd && s_axi_rvalid) begin
                pd = 1'h0;
                rd = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'h0;
            end
        end
    endtask
    task automatic wait_step(input logic [1:0] s);
        for (int i = 0; i < 4000 && gain_step !== s; i++) begin
            @(negedge aclk);
            if (gain_step === 2'h3) chk(gain_step, s);
        end
        chk(gain_step, s);
    endtask
    task automatic t_reset;
        logic [7:0] a [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
        logic [31:0] e [8] = '{32'h10, 32'h400000, 32'h404, 32'h27f, 32'h80, 32'h100, 32'hd5, 32'h9b};
        for (int i = 0; i < 8; i++) begin
            axi_rd(a[i]);
            chk(rd, e[i]);
        end
        chk({gain_step, double_conversion_mode, gain_before_mixer}, 32'h3);
        chk(delog_value, 32'h100);
    endtask
    task automatic t_atten;
        axi_wr(DAGC_CTRL_OFFS, 32'h0000_000f);
        @(negedge aclk);
        chk({if_attenuation_setting, gain_after_polyphase, gain_before_mixer, double_conversion_mode}, 32'h3c);
        axi_wr(DAGC_CTRL_OFFS, 32'h0000_001f);
        @(negedge aclk);
        chk({if_attenuation_setting, gain_after_polyphase, gain_before_mixer, double_conversion_mode}, 32'h7b);
        chk(resp, DAGC_RESP_OKAY);
        axi_wr(DAGC_STATUS_OFFS, 32'h0000_0003);
        chk(resp, DAGC_RESP_DECERR);
        axi_rd(8'h28);
        chk(rd, 32'h0);
        chk(resp, DAGC_RESP_DECERR);
    endtask
    task automatic t_gain;
        level <= 10'h064;
        axi_wr(DAGC_RSSI_CORR_OFFS, 32'h0080_0005);
        repeat (20) @(posedge aclk);
        @(negedge aclk);
        chk(corrected_rssi, 32'h0d2);
        axi_wr(DAGC_RSSI_CORR_OFFS, 32'h0040_0000);
        // Decay kept sixteen times slower than attack so keyed carriers do not move the gain.
        axi_wr(DAGC_PMF_OFFS, 32'h0000_0400);
        axi_wr(DAGC_THR_UP_OFFS, 32'h0000_0300);
        level <= 10'h3e8;
        wait_step(2'h1);
        chk(digital_gain_correction, 32'h09b);
        axi_wr(DAGC_THR_UP_OFFS, 32'h0000_0100);
        wait_step(2'h2);
        chk(digital_gain_correction, 32'h136);
        // With an attack shift of zero the level settles on the input plus two correction steps.
        repeat (24) @(posedge aclk);
        @(negedge aclk);
        chk(filtered_level, 32'd1310);
        chk(delog_index, 32'h00);
        axi_rd(DAGC_STATUS_OFFS);
        chk(rd[1:0], 32'h2);
        chk(rd[27:16], 32'd1310);
        level <= 10'h000;
        repeat (16) @(posedge aclk);
        @(negedge aclk);
        chk(delog_index, 32'h80);
        wait_step(2'h0);
        chk(digital_gain_correction, 32'h000);
    endtask
    task automatic results;
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        aclk = 1'h0;
        forever #2.5 aclk = ~aclk;
    end
    initial begin
        #100000;
        num_errors++;
        results;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, level} = '0;
        s_axi_wstrb = 4'hf;
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset;
        t_atten;
        t_gain;
        results;
    end
endmodule // test_digital_agc_peak_filter
